//--- hdl/tcr_match_unit.sv
`include "tcr_params.svh"
`default_nettype none
// One equality comparator with the zero-compare arming behaviour
module tcr_match_unit (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Counter view
    input  wire logic        running,
    input  wire logic        countStep,
    input  wire logic        counterCleared,
    input  wire logic [15:0] countNow,
    input  wire logic [15:0] compareVal,
    // Result
    output logic             matchHit
);
    logic zeroArmed_ff;

    // Zero compare is armed only by a clear; the start itself never arms it.
    // A clear seen while the tick is low keeps the arming until the next step or until counting stops.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            zeroArmed_ff <= 1'b0;
        end else if (!running) begin
            zeroArmed_ff <= 1'b0;
        end else if (countStep) begin
            zeroArmed_ff <= 1'b0;
        end else if (counterCleared) begin
            zeroArmed_ff <= 1'b1;
        end
    end

    always_comb begin
        if (compareVal == `TCR_ZERO) begin
            matchHit = running && countStep && (counterCleared || zeroArmed_ff)
                       && (countNow == `TCR_ZERO);
        end else begin
            matchHit = running && countStep
                       && (countNow + `TCR_ONE == compareVal);
        end
    end

    a_zero_no_early : assert property (@(posedge clk) disable iff (rst)
        (running && !$past(running) && compareVal == `TCR_ZERO) |-> !matchHit)
        else $error("zero compare matched at the start of counting");
endmodule
`default_nettype wire

//--- hdl/tcr_params.svh
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH
`define TCR_WIDTH     16
`define TCR_ZERO      16'h0000
`define TCR_ONE       16'h0001
`define TCR_MAX       16'hFFFF
`define TCR_COUNT_RST 16'h0000
`endif

//--- hdl/tcr_pkg.sv
`default_nettype none
package tcr_pkg;
    typedef enum logic [6:0] {
        TCR_INTERVAL  = 7'h01,
        TCR_SQUARE    = 7'h02,
        TCR_EVENT     = 7'h04,
        TCR_EDGECLR   = 7'h08,
        TCR_MATCHCLR  = 7'h10,
        TCR_FREERUN   = 7'h20,
        TCR_PATTERN   = 7'h40
    } tcr_mode_t;
    typedef struct packed {
        logic [15:0] comparePrimary;
        logic [15:0] compareSecondary;
    } tcr_cmp_t;
    typedef struct packed {
        logic primaryMatch;
        logic secondaryMatch;
    } tcr_match_t;
endpackage
`default_nettype wire

//--- hdl/tcr_timer_compare.sv
`include "tcr_params.svh"
`default_nettype none
module tcr_timer_compare (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Control
    input  wire logic               countEnable,
    input  wire logic               countTick,
    input  wire tcr_pkg::tcr_mode_t modeSel,
    input  wire tcr_pkg::tcr_cmp_t  compareRegs,
    input  wire logic               validEdgeInput,
    // Status
    output logic [15:0]             timerCountValue,
    output tcr_pkg::tcr_match_t     matchIrq,
    output logic                    secondaryMatchIrq,
    output logic                    timerOutput,
    output logic                    pulsePatternOutput
);
    logic [15:0]         timerCount_ff;
    logic [15:0]         nxt_timerCount;
    logic                clearEvent;
    logic                cleared_ff;
    logic                hitPrimary;
    logic                hitSecondary;
    logic                matchClearOk;
    logic                timerOut_ff;
    logic                pattern_ff;
    tcr_pkg::tcr_match_t irq_ff;
    logic                secIrq_ff;
    logic                started_ff;

    // Clear & start by match is honoured only with the documented settings
    assign matchClearOk = (modeSel == tcr_pkg::TCR_MATCHCLR)
                          && (compareRegs.comparePrimary != `TCR_ZERO)
                          && (compareRegs.compareSecondary == `TCR_ZERO);
    // Any clear restarts the count at zero; the overflow wrap counts as a clear too,
    // so a zero compare fires one step after every wrap.
    assign clearEvent = countEnable && countTick
                        && (((modeSel == tcr_pkg::TCR_EDGECLR) && validEdgeInput)
                            || (matchClearOk && hitPrimary)
                            || (timerCount_ff == `TCR_MAX));

    // Stopping parks the count at zero, which is also the value counting starts from
    always_comb begin
        nxt_timerCount = timerCount_ff;
        if (!countEnable) begin
            nxt_timerCount = `TCR_COUNT_RST;
        end else if (countTick && clearEvent) begin
            nxt_timerCount = `TCR_ZERO;
        end else if (countTick) begin
            nxt_timerCount = timerCount_ff + `TCR_ONE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timerCount_ff <= `TCR_COUNT_RST;
        end else begin
            timerCount_ff <= nxt_timerCount;
        end
    end

    // Flags a clear seen on the previous cycle only (feeds the arming)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cleared_ff <= 1'b0;
            started_ff <= 1'b0;
        end else begin
            cleared_ff <= clearEvent;
            started_ff <= countEnable;
        end
    end

    // Both comparators see the same counter view; only the compare value differs.
    // The secondary one is normally unused in the periodic modes, and its
    // interrupt is meant to be masked outside this block.
    tcr_match_unit uPrimary (
        .clk            (clk),
        .rst            (rst),
        .running        (countEnable),
        .countStep      (countTick),
        .counterCleared (cleared_ff),
        .countNow       (timerCount_ff),
        .compareVal     (compareRegs.comparePrimary),
        .matchHit       (hitPrimary)
    );

    tcr_match_unit uSecondary (
        .clk            (clk),
        .rst            (rst),
        .running        (countEnable),
        .countStep      (countTick),
        .counterCleared (cleared_ff),
        .countNow       (timerCount_ff),
        .compareVal     (compareRegs.compareSecondary),
        .matchHit       (hitSecondary)
    );

    // Match pulses last one cycle, aligned with the counter update
    // The secondary pulse leaves twice: in the pair and on its own pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_ff <= '0;
            secIrq_ff <= 1'b0;
        end else begin
            irq_ff.primaryMatch <= hitPrimary;
            irq_ff.secondaryMatch <= hitSecondary;
            secIrq_ff <= hitSecondary;
        end
    end

    // Square wave toggles on primary match; output stays put without a match
    // Stopping the timer parks the output low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timerOut_ff <= 1'b0;
        end else if (!countEnable) begin
            timerOut_ff <= 1'b0;
        end else if (hitPrimary && (modeSel == tcr_pkg::TCR_SQUARE)) begin
            timerOut_ff <= ~timerOut_ff;
        end
    end

    // Pulse pattern: high from secondary match until primary match
    // Secondary below primary is left to software; with both equal the output never rises
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pattern_ff <= 1'b0;
        end else if (!countEnable || modeSel != tcr_pkg::TCR_PATTERN) begin
            pattern_ff <= 1'b0;
        end else if (hitPrimary) begin
            pattern_ff <= 1'b0;
        end else if (hitSecondary) begin
            pattern_ff <= 1'b1;
        end
    end

    // Every output comes straight from a register
    assign timerCountValue    = timerCount_ff;
    assign matchIrq           = irq_ff;
    assign secondaryMatchIrq  = secIrq_ff;
    assign timerOutput        = timerOut_ff;
    assign pulsePatternOutput = pattern_ff;

    // The match pulses and the outputs are registered, so a check on them looks one
    // edge past the comparator hit that causes them. Checks on the zero compare
    // skip cycles with a valid edge: an edge there restarts the count at zero.

    a_wrap_to_zero : assert property (@(posedge clk) disable iff (rst)
        (countEnable && countTick && timerCount_ff == `TCR_MAX && $past(countEnable))
        |=> (timerCount_ff == `TCR_ZERO))
        else $error("counter did not wrap to zero");

    a_count_step : assert property (@(posedge clk) disable iff (rst)
        (countEnable && countTick && !clearEvent)
        |=> (timerCount_ff == $past(timerCount_ff) + 16'h0001))
        else $error("counter did not advance by one");

    a_tick_hold : assert property (@(posedge clk) disable iff (rst)
        (countEnable && !countTick)
        |=> (timerCount_ff == $past(timerCount_ff)))
        else $error("counter moved without a count step");

    a_no_start_irq : assert property (@(posedge clk) disable iff (rst)
        (countEnable && !started_ff && !clearEvent && compareRegs.comparePrimary == 16'h0000)
        |=> !matchIrq.primaryMatch ##1 !matchIrq.primaryMatch)
        else $error("zero compare matched at start");

    a_zero_match_time : assert property (@(posedge clk) disable iff (rst)
        (matchIrq.primaryMatch && compareRegs.comparePrimary == 16'h0000
         && !$past(validEdgeInput)) |-> timerCount_ff == 16'h0001)
        else $error("zero compare match not at step to one");

    a_zero_first : assert property (@(posedge clk) disable iff (rst)
        (countEnable && countTick && cleared_ff && !clearEvent
         && timerCount_ff == 16'h0000 && compareRegs.comparePrimary == 16'h0000)
        |=> matchIrq.primaryMatch)
        else $error("zero compare missed the step from zero to one");

    a_match_clear : assert property (@(posedge clk) disable iff (rst)
        (countEnable && countTick && hitPrimary && matchClearOk) |=> timerCount_ff == 16'h0000)
        else $error("match clear did not clear counter");

    a_clear_refused : assert property (@(posedge clk) disable iff (rst)
        (countEnable && countTick && hitPrimary && modeSel == tcr_pkg::TCR_MATCHCLR
         && !matchClearOk && timerCount_ff != `TCR_MAX)
        |=> timerCount_ff == $past(timerCount_ff) + 16'h0001)
        else $error("match clear taken with the wrong compare settings");

    a_edge_clear : assert property (@(posedge clk) disable iff (rst)
        (countEnable && countTick && validEdgeInput && modeSel == tcr_pkg::TCR_EDGECLR)
        |=> timerCount_ff == 16'h0000)
        else $error("valid edge did not clear counter");

    a_match_value : assert property (@(posedge clk) disable iff (rst)
        (matchIrq.secondaryMatch && compareRegs.compareSecondary != 16'h0000
         && $stable(compareRegs.compareSecondary) && !$past(validEdgeInput))
        |-> timerCount_ff == compareRegs.compareSecondary)
        else $error("secondary match at wrong count");

    a_sec_irq_pin : assert property (@(posedge clk) disable iff (rst)
        (countEnable && hitSecondary)
        |=> secondaryMatchIrq)
        else $error("secondary match pin missed its pulse");

    a_out_hold : assert property (@(posedge clk) disable iff (rst)
        (countEnable && $past(countEnable) && !$past(hitPrimary))
        |-> $stable(timerOutput))
        else $error("timer output changed without a match");

    a_square_toggle : assert property (@(posedge clk) disable iff (rst)
        (countEnable && hitPrimary && modeSel == tcr_pkg::TCR_SQUARE)
        |=> timerOutput != $past(timerOutput))
        else $error("square output missed its toggle");

    a_pattern_set : assert property (@(posedge clk) disable iff (rst)
        (countEnable && modeSel == tcr_pkg::TCR_PATTERN && hitSecondary && !hitPrimary)
        |=> pulsePatternOutput)
        else $error("pattern output did not rise on secondary match");

    a_pattern_clear : assert property (@(posedge clk) disable iff (rst)
        (countEnable && modeSel == tcr_pkg::TCR_PATTERN && hitPrimary)
        |=> !pulsePatternOutput)
        else $error("pattern output did not fall on primary match");

    a_stop_quiet : assert property (@(posedge clk) disable iff (rst)
        (!countEnable)
        |=> (timerCount_ff == 16'h0000 && !matchIrq.primaryMatch
             && !matchIrq.secondaryMatch && !timerOutput))
        else $error("stopped timer did not park at zero");
endmodule
`default_nettype wire

//--- sim/tcr_timer_compare_tb_top.sv
`default_nettype none
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin fails++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module tcr_timer_compare_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                countEnable = 1'b0;
    logic                countTick = 1'b1;
    logic                validEdgeInput = 1'b0;
    tcr_pkg::tcr_mode_t  modeSel = tcr_pkg::TCR_FREERUN;
    tcr_pkg::tcr_cmp_t   compareRegs = '0;
    logic [15:0]         timerCountValue;
    tcr_pkg::tcr_match_t matchIrq;
    logic                secondaryMatchIrq;
    logic                timerOutput;
    logic                pulsePatternOutput;
    int                  fails = 0;
    int                  checksDone = 0;
    always #12.5 clk = ~clk;
    // Tick held high except in the slow-tick scenario
    tcr_timer_compare i_dut (
        .clk(clk), .rst(rst), .countEnable(countEnable), .countTick(countTick),
        .modeSel(modeSel), .compareRegs(compareRegs), .validEdgeInput(validEdgeInput),
        .timerCountValue(timerCountValue), .matchIrq(matchIrq),
        .secondaryMatchIrq(secondaryMatchIrq), .timerOutput(timerOutput),
        .pulsePatternOutput(pulsePatternOutput)
    );
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic stepw(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Stop, load mode and compares, restart; counter is 0 until the next edge
    task automatic run(input tcr_pkg::tcr_mode_t m, input logic [15:0] p, input logic [15:0] s);
        @(posedge clk);
        countEnable <= 1'b0;
        modeSel <= m;
        compareRegs <= '{comparePrimary: p, compareSecondary: s};
        @(posedge clk);
        countEnable <= 1'b1;
    endtask
    task automatic wrap_zero();
        run(tcr_pkg::TCR_FREERUN, 16'h0000, 16'hFFFF);
        stepw(1);
        `CHK(timerCountValue, 16'h0001)
        `CHK(matchIrq.primaryMatch, 1'b0)
        stepw(16'hFFFE);
        `CHK(timerCountValue, 16'hFFFF)
        `CHK(secondaryMatchIrq, 1'b1)
        `CHK(matchIrq.secondaryMatch, 1'b1)
        stepw(1);
        `CHK(timerCountValue, 16'h0000)
        `CHK(matchIrq.primaryMatch, 1'b0)
        stepw(1);
        `CHK(matchIrq.primaryMatch, 1'b1)
    endtask
    task automatic edge_clear();
        run(tcr_pkg::TCR_EDGECLR, 16'h0000, 16'h0100);
        stepw(3);
        @(posedge clk);
        validEdgeInput <= 1'b1;
        @(posedge clk);
        validEdgeInput <= 1'b0;
        #1;
        `CHK(timerCountValue, 16'h0000)
        `CHK(matchIrq.primaryMatch, 1'b0)
        stepw(1);
        `CHK(matchIrq.primaryMatch, 1'b1)
    endtask
    // Zero compare with the tick held low right after a valid-edge clear
    task automatic slow_tick();
        run(tcr_pkg::TCR_EDGECLR, 16'h0000, 16'h0010);
        stepw(2);
        @(posedge clk);
        validEdgeInput <= 1'b1;
        @(posedge clk);
        validEdgeInput <= 1'b0;
        countTick <= 1'b0;
        repeat (2) @(posedge clk);
        countTick <= 1'b1;
        #1;
        `CHK(timerCountValue, 16'h0000)
        `CHK(matchIrq.primaryMatch, 1'b0)
        stepw(1);
        `CHK(timerCountValue, 16'h0001)
        `CHK(matchIrq.primaryMatch, 1'b1)
    endtask
    task automatic match_clear();
        run(tcr_pkg::TCR_MATCHCLR, 16'h0005, 16'h0000);
        stepw(4);
        `CHK(timerCountValue, 16'h0004)
        stepw(1);
        `CHK(timerCountValue, 16'h0000)
        // Secondary nonzero: no clear, plain match instead
        run(tcr_pkg::TCR_MATCHCLR, 16'h0005, 16'h0007);
        stepw(5);
        `CHK(timerCountValue, 16'h0005)
        `CHK(matchIrq.primaryMatch, 1'b1)
    endtask
    task automatic outputs();
        run(tcr_pkg::TCR_SQUARE, 16'h0003, 16'hFFFF);
        stepw(2);
        `CHK(timerOutput, 1'b0)
        stepw(1);
        `CHK(timerOutput, 1'b1)
        stepw(1);
        `CHK(timerOutput, 1'b1)
        run(tcr_pkg::TCR_PATTERN, 16'h0008, 16'h0003);
        stepw(3);
        `CHK(secondaryMatchIrq, 1'b1)
        `CHK(pulsePatternOutput, 1'b1)
        stepw(1);
        `CHK(secondaryMatchIrq, 1'b0)
        stepw(4);
        `CHK(timerCountValue, 16'h0008)
        `CHK(matchIrq.primaryMatch, 1'b1)
        `CHK(pulsePatternOutput, 1'b0)
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wrap_zero();
        edge_clear();
        slow_tick();
        match_clear();
        outputs();
        stop_test();
    end
    // About 66000 cycles expected; cut off well beyond
    initial begin
        #2500000;
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
